// [common/isc_map.svh]
// Register offsets, field positions, mode codes and reset values of the I2C slave port
`ifndef ISC_MAP_SVH
`define ISC_MAP_SVH

// Register offsets on the plain register port
`define ISC_OFF_CTRL      3'h0
`define ISC_OFF_BUF       3'h1
`define ISC_OFF_ADDR      3'h2
`define ISC_OFF_ADDR_HI   3'h3
`define ISC_OFF_INT_STAT  3'h4
`define ISC_OFF_INT_MASK  3'h5
`define ISC_OFF_STATUS    3'h6

// Control register fields
`define ISC_BIT_WRITE_COLLISION_FLAG      7
`define ISC_BIT_OVF       6
`define ISC_BIT_EN        5
`define ISC_BIT_CKP       4
`define ISC_MODE_HI       3

// Mode field codes
`define ISC_MODE_SL7      4'h6
`define ISC_MODE_SL10     4'h7
`define ISC_MODE_MSKLD    4'h9
`define ISC_MODE_FWM      4'hb
`define ISC_MODE_SL7_SP   4'he
`define ISC_MODE_SL10_SP  4'hf

// Interrupt status and mask bits
`define ISC_INT_BYTE      0
`define ISC_INT_START     1
`define ISC_INT_STOP      2

// Reset values
`define ISC_CTRL_RST      8'h00
`define ISC_ADDR_RST      8'h00
`define ISC_MASK_RST      8'hff

// Ten-bit address header pattern and bit count of a byte
`define ISC_TEN_HDR       5'h1e
`define ISC_BYTE_BITS     4'h8
`define ISC_TX_LAST       3'h7

`endif

// [common/isc_pkg.sv]
// Types shared by the I2C slave port control logic
package isc_pkg;

    // Bus-side phase of the slave engine
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ADDR2 = 3'b010,
        ST_ACK   = 3'b011,
        ST_RX    = 3'b100,
        ST_HOLD  = 3'b101,
        ST_TX    = 3'b110,
        ST_TACK  = 3'b111
    } isc_state_t;

    // One bit per bus line, used for levels and for output enables
    typedef struct packed {
        logic scl;
        logic sda;
    } isc_line_t;

    // Whole state of the control block
    typedef struct packed {
        isc_state_t state;
        logic [7:0] ctrl;
        logic [7:0] sbuf;
        logic       bf;
        logic [7:0] saddr;
        logic [1:0] saddr_hi;
        logic [7:0] amask;
        logic [2:0] istat;
        logic [2:0] imask;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic       rw;
        logic       addr2;
        logic       ten_ok;
        isc_line_t  oe;
        isc_line_t  last;
        logic [7:0] rdata;
    } isc_st_t;

endpackage : isc_pkg

// [core/isc_sync.sv]
// Multi-stage synchroniser for levels entering the system clock domain
`timescale 1ns/1ns
module isc_sync #(
    parameter int WIDTH  = 2,
    parameter int STAGES = 2
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    // Fewer than two stages would leave metastability exposed
    if (STAGES < 2 || WIDTH < 1) begin : g_bad
        $error("isc_sync needs at least two stages and one bit");
    end

    logic [STAGES-1:0][WIDTH-1:0] pipe_r;   // Stage 0 is read only by stage 1

    // Shift chain; idle bus lines are high, so reset to ones
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pipe_r <= '1;
        end else begin
            pipe_r <= {pipe_r[STAGES-2:0], d_in};
        end
    end

    assign q_out = pipe_r[STAGES-1];

endmodule : isc_sync

// [core/isc_ctrl.sv]
// I2C slave port control: control register, clock stretch, flags and slave engine
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "isc_map.svh"

module isc_ctrl
    import isc_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic [2:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    output logic            irq_out,
    input  wire isc_line_t  line_in,
    output isc_line_t       line_out,
    output isc_line_t       line_oe_out,
    output logic            pins_owned_out
);

    isc_st_t    st_r;        // Registered state
    isc_st_t    st_nxt;      // Next state
    isc_line_t  ln;          // Synchronised bus lines
    logic [3:0] mode;        // Mode field
    logic       sl7;         // Seven-bit slave mode
    logic       sl10;        // Ten-bit slave mode
    logic       sp_irq;      // Start/Stop interrupts wanted
    logic       slave_on;    // Slave engine serves the bus
    logic       mskld;       // Address location maps to mask
    logic       scl_rise;    // SCL rising edge
    logic       scl_fall;    // SCL falling edge
    logic       start_det;   // SDA falls while SCL high
    logic       stop_det;    // SDA rises while SCL high
    logic       match7;      // Masked seven-bit match of shift
    logic       match_lo;    // Masked low-byte match of shift
    logic       hdr_ok;      // Ten-bit header names this slave

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser

    // Both lines come from the far master, so two flops before any logic
    isc_sync #(
        .WIDTH  (2),
        .STAGES (2)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .d_in       (line_in),
        .q_out      (ln)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Decodes

    // Mode decode; any code not listed leaves the engine idle
    assign mode     = st_r.ctrl[`ISC_MODE_HI:0];
    assign sl7      = (mode == `ISC_MODE_SL7)  || (mode == `ISC_MODE_SL7_SP);
    assign sl10     = (mode == `ISC_MODE_SL10) || (mode == `ISC_MODE_SL10_SP);
    assign sp_irq   = (mode == `ISC_MODE_SL7_SP) || (mode == `ISC_MODE_SL10_SP);
    assign slave_on = st_r.ctrl[`ISC_BIT_EN] && (sl7 || sl10);
    assign mskld    = (mode == `ISC_MODE_MSKLD);

    // Edges from the synchronised level and its one-cycle-old copy
    assign scl_rise  = ln.scl & ~st_r.last.scl;
    assign scl_fall  = ~ln.scl & st_r.last.scl;
    assign start_det = ln.scl & st_r.last.scl & ~ln.sda & st_r.last.sda;
    assign stop_det  = ln.scl & st_r.last.scl & ln.sda & ~st_r.last.sda;

    // Address compares; a clear mask bit makes that bit a don't-care in match7 and match_lo, hdr_ok compares unmasked
    assign match7   = (((st_r.shift[7:1] ^ st_r.saddr[7:1]) & st_r.amask[7:1]) == 7'h00);
    assign match_lo = (((st_r.shift ^ st_r.saddr) & st_r.amask) == 8'h00);
    assign hdr_ok   = (st_r.shift[7:3] == `ISC_TEN_HDR) && (st_r.shift[2:1] == st_r.saddr_hi);

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Software access first, hardware events after so that a hardware update wins over a software one
    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = 8'h00;
        st_nxt.last  = ln;

        // Register writes
        if (wr_in) begin
            case (addr_in)
                `ISC_OFF_CTRL: begin
                    st_nxt.ctrl = wdata_in;
                end
                `ISC_OFF_BUF: begin
                    if (st_r.state == ST_TX) begin
                        st_nxt.ctrl[`ISC_BIT_WRITE_COLLISION_FLAG] = 1'b1;   // Write dropped
                    end else begin
                        st_nxt.sbuf = wdata_in;
                        st_nxt.bf   = 1'b1;
                    end
                end
                `ISC_OFF_ADDR: begin
                    if (mskld) begin
                        st_nxt.amask = wdata_in;
                    end else begin
                        st_nxt.saddr = wdata_in;
                    end
                end
                `ISC_OFF_ADDR_HI:  st_nxt.saddr_hi = wdata_in[1:0];
                `ISC_OFF_INT_STAT: st_nxt.istat    = st_r.istat & ~wdata_in[2:0];
                `ISC_OFF_INT_MASK: st_nxt.imask    = wdata_in[2:0];
                default: ;
            endcase
        end

        // Register reads; data stand in the next cycle only
        if (rd_in) begin
            case (addr_in)
                `ISC_OFF_CTRL: st_nxt.rdata = st_r.ctrl;
                `ISC_OFF_BUF: begin
                    st_nxt.rdata = st_r.sbuf;
                    st_nxt.bf    = 1'b0;                     // Reading empties it
                end
                `ISC_OFF_ADDR:     st_nxt.rdata = mskld ? st_r.amask : st_r.saddr;
                `ISC_OFF_ADDR_HI:  st_nxt.rdata = {6'h00, st_r.saddr_hi};
                `ISC_OFF_INT_STAT: st_nxt.rdata = {5'h00, st_r.istat};
                `ISC_OFF_INT_MASK: st_nxt.rdata = {5'h00, st_r.imask};
                `ISC_OFF_STATUS:   st_nxt.rdata = {3'h0, st_r.bf, st_r.rw, st_r.state};
                default:           st_nxt.rdata = 8'h00;
            endcase
        end

        // Slave engine
        if (!slave_on) begin
            // Disabled, master-idle, mask-load or reserved: let go of both lines
            st_nxt.state  = ST_IDLE;
            st_nxt.oe     = '0;
            st_nxt.ten_ok = 1'b0;
        end else if (start_det) begin
            // Start or repeated start always restarts address reception
            st_nxt.state = ST_ADDR;
            st_nxt.cnt   = 4'h0;
            st_nxt.oe    = '0;
            if (sp_irq) begin
                st_nxt.istat[`ISC_INT_START] = 1'b1;
            end
        end else if (stop_det) begin
            st_nxt.state  = ST_IDLE;
            st_nxt.oe     = '0;
            st_nxt.ten_ok = 1'b0;
            if (sp_irq) begin
                st_nxt.istat[`ISC_INT_STOP] = 1'b1;
            end
        end else begin
            case (st_r.state)
                ST_ADDR, ST_ADDR2, ST_RX: begin
                    // Shift in on rising SCL, judge after the eighth falling edge
                    if (scl_rise) begin
                        st_nxt.shift = {st_r.shift[6:0], ln.sda};
                        st_nxt.cnt   = st_r.cnt + 4'h1;
                    end else if (scl_fall && st_r.cnt == `ISC_BYTE_BITS) begin
                        st_nxt.cnt   = 4'h0;
                        st_nxt.state = ST_IDLE;              // Not for us unless acked below
                        st_nxt.addr2 = 1'b0;
                        if (st_r.state == ST_ADDR) begin
                            st_nxt.rw = st_r.shift[0];
                            if (sl7 && match7) begin
                                st_nxt.state  = ST_ACK;
                                st_nxt.oe.sda = 1'b1;
                            end else if (sl10 && hdr_ok && (!st_r.shift[0] || st_r.ten_ok)) begin
                                st_nxt.state  = ST_ACK;
                                st_nxt.oe.sda = 1'b1;
                                st_nxt.addr2  = ~st_r.shift[0];
                            end
                        end else if (st_r.state == ST_ADDR2) begin
                            if (match_lo) begin
                                st_nxt.state  = ST_ACK;
                                st_nxt.oe.sda = 1'b1;
                                st_nxt.ten_ok = 1'b1;
                            end
                        end else if (st_r.bf) begin
                            // Unread byte still held: flag it and stop answering
                            st_nxt.ctrl[`ISC_BIT_OVF] = 1'b1;
                        end else begin
                            st_nxt.sbuf   = st_r.shift;
                            st_nxt.bf     = 1'b1;
                            st_nxt.state  = ST_ACK;
                            st_nxt.oe.sda = 1'b1;
                            st_nxt.istat[`ISC_INT_BYTE] = 1'b1;
                        end
                    end
                end
                ST_ACK: begin
                    // Acknowledge lasts one SCL low-high-low
                    if (scl_fall) begin
                        st_nxt.oe.sda = 1'b0;
                        if (st_r.addr2) begin
                            st_nxt.state = ST_ADDR2;
                        end else if (st_r.rw) begin
                            st_nxt.state  = ST_HOLD;         // Stretch after read match
                            st_nxt.oe.scl = 1'b1;
                            st_nxt.ctrl[`ISC_BIT_CKP] = 1'b0;
                            st_nxt.istat[`ISC_INT_BYTE] = 1'b1;
                        end else begin
                            st_nxt.state = ST_RX;
                        end
                    end
                end
                ST_HOLD: begin
                    // SCL stays low until software sets the hold bit
                    if (st_r.ctrl[`ISC_BIT_CKP]) begin
                        st_nxt.state  = ST_TX;
                        st_nxt.shift  = st_r.sbuf;
                        st_nxt.bf     = 1'b0;
                        st_nxt.cnt    = 4'h0;
                        st_nxt.oe.scl = 1'b0;
                        st_nxt.oe.sda = ~st_r.sbuf[7];
                    end
                end
                ST_TX: begin
                    // Next bit after each falling edge, release after the eighth
                    if (scl_fall) begin
                        st_nxt.cnt = st_r.cnt + 4'h1;
                        if (st_r.cnt[2:0] == `ISC_TX_LAST) begin
                            st_nxt.state  = ST_TACK;
                            st_nxt.oe.sda = 1'b0;
                        end else begin
                            st_nxt.shift  = {st_r.shift[6:0], 1'b0};
                            st_nxt.oe.sda = ~st_r.shift[6];
                        end
                    end
                end
                ST_TACK: begin
                    // Master ack keeps the read going, a nack ends it
                    if (scl_rise) begin
                        st_nxt.rw = ~ln.sda;
                    end else if (scl_fall) begin
                        if (st_r.rw) begin
                            st_nxt.state  = ST_HOLD;
                            st_nxt.oe.scl = 1'b1;
                            st_nxt.ctrl[`ISC_BIT_CKP] = 1'b0;
                            st_nxt.istat[`ISC_INT_BYTE] = 1'b1;
                        end else begin
                            st_nxt.state = ST_IDLE;
                        end
                    end
                end
                default: st_nxt.state = ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    // Synchronous reset to documented values; mask compares all bits
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            st_r       <= '0;
            st_r.ctrl  <= `ISC_CTRL_RST;
            st_r.saddr <= `ISC_ADDR_RST;
            st_r.amask <= `ISC_MASK_RST;
            st_r.last  <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Open-drain: only ever pull low; enables are registered
    assign line_out       = '0;
    assign line_oe_out    = st_r.oe;
    assign pins_owned_out = st_r.ctrl[`ISC_BIT_EN];
    assign rdata_out      = st_r.rdata;
    assign irq_out        = |(st_r.istat & st_r.imask);

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    a_write_collision_flag_set: assert property (wr_in && addr_in == `ISC_OFF_BUF && st_r.state == ST_TX
        |=> st_r.ctrl[`ISC_BIT_WRITE_COLLISION_FLAG] && $stable(st_r.sbuf))
        else $error("write collision not flagged");

    a_ovf_set: assert property (slave_on && st_r.state == ST_RX && scl_fall && st_r.bf
        && st_r.cnt == `ISC_BYTE_BITS |=> st_r.ctrl[`ISC_BIT_OVF] && !st_r.oe.sda)
        else $error("receive overflow not flagged");

    a_pins_off: assert property ((!st_r.ctrl[`ISC_BIT_EN])[*2]
        |-> line_oe_out == 2'b00 && !pins_owned_out)
        else $error("lines driven while port disabled");

    a_mode_idle: assert property ((st_r.ctrl[`ISC_BIT_EN] && !sl7 && !sl10)[*2]
        |-> st_r.state == ST_IDLE && st_r.oe == 2'b00)
        else $error("engine active in idle mode");

    a_start_irq: assert property (slave_on && sp_irq && start_det
        |=> st_r.istat[`ISC_INT_START] && st_r.state == ST_ADDR)
        else $error("start interrupt missing");

    a_start_quiet: assert property (!sp_irq && !st_r.istat[`ISC_INT_START]
        && !(wr_in && addr_in == `ISC_OFF_CTRL) |=> !st_r.istat[`ISC_INT_START])
        else $error("start interrupt in plain mode");

    a_read_stretch: assert property (slave_on && st_r.state == ST_ACK && st_r.rw
        && !st_r.addr2 && scl_fall && !start_det && !stop_det
        |=> st_r.state == ST_HOLD && st_r.oe.scl)
        else $error("no stretch after read match");

    a_hold_low: assert property (st_r.state == ST_HOLD && !st_r.ctrl[`ISC_BIT_CKP]
        |-> line_oe_out.scl)
        else $error("clock not held");

    a_hold_release: assert property (slave_on && st_r.state == ST_HOLD
        && st_r.ctrl[`ISC_BIT_CKP] && !start_det && !stop_det
        |=> st_r.state == ST_TX && !line_oe_out.scl)
        else $error("clock not released");

    a_mask_map: assert property (wr_in && addr_in == `ISC_OFF_ADDR && mskld
        |=> st_r.amask == $past(wdata_in) && $stable(st_r.saddr))
        else $error("mask write misrouted");

    c_start_seen:  cover property (slave_on && sp_irq && start_det);
    c_read_hold:   cover property (st_r.state == ST_HOLD ##1 st_r.state == ST_TX);
    c_overflow:    cover property ($rose(st_r.ctrl[`ISC_BIT_OVF]));
    c_collision:   cover property ($rose(st_r.ctrl[`ISC_BIT_WRITE_COLLISION_FLAG]));

endmodule : isc_ctrl

// [tb/isc_mst_model.sv]
// Behavioural I2C bus master that drives the far side of the slave port
`timescale 1ns/1ns
module isc_mst_model (
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_oe_out,
    output logic      sda_oe_out
);
    localparam int QTR = 80;  // Quarter of the 320 ns bit time

    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus: both lines released to the pull-ups
    initial begin
        scl_oe_out = 1'b0;
        sda_oe_out = 1'b0;
    end

    // Release SCL and wait out a stretch; bounded so a stuck slave cannot hang us
    task automatic scl_up;
        scl_oe_out = 1'b0;
        #0;  // Let the wire follow first, so an unstretched bit stays 320 ns
        for (int i = 0; i < 4000 && scl_in !== 1'b1; i++) begin
            #10;
        end
    endtask : scl_up

    // One bit: data set early in the low phase, sampled mid high phase
    task automatic clk_bit(input logic b, output logic s);
        #40;
        sda_oe_out = ~b;
        #120;
        scl_up();
        #QTR;
        s = sda_in;
        #QTR;
        scl_oe_out = 1'b1;
    endtask : clk_bit

    // Start, also usable as repeated Start from a low clock
    task automatic start_c;
        #QTR;
        sda_oe_out = 1'b0;
        #QTR;
        scl_up();
        #QTR;
        sda_oe_out = 1'b1;
        #QTR;
        scl_oe_out = 1'b1;
    endtask : start_c

    // Stop: SDA rises while SCL is high
    task automatic stop_c;
        #QTR;
        sda_oe_out = 1'b1;
        #QTR;
        scl_up();
        #QTR;
        sda_oe_out = 1'b0;
        #QTR;
    endtask : stop_c

    // Byte out MSB first, then the slave's acknowledge
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(v[i], s);
        end
        clk_bit(1'b1, s);
        ack = (s === 1'b0);
    endtask : wbyte

    // Byte in MSB first, then our acknowledge (1 pulls SDA low)
    task automatic rbyte(output logic [7:0] v, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            v[i] = s;
        end
        clk_bit(~ack, s);
    endtask : rbyte
endmodule : isc_mst_model

// [tb/i2c_slave_port_control_tb.sv]
// Self-checking bench for the I2C slave port control block
`timescale 1ns/1ns
`include "isc_map.svh"

`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("FAIL %0t got %h exp %h", $time, (got), (exp)); \
    end \
end

module i2c_slave_port_control_tb
    import isc_pkg::*;
();
    logic       sys_clk_in;  // 25 MHz system clock
    logic       rst_in;      // Synchronous reset
    logic [2:0] addr_r;      // Register index
    logic [7:0] wdata_r;     // Write data
    logic       wr_r;        // Write strobe
    logic       rd_r;        // Read strobe
    logic [7:0] rdata;       // Read data
    logic       irq;         // Interrupt level
    isc_line_t  line_lvl;    // Resolved wire levels
    isc_line_t  line_oe;     // Slave pull-downs
    logic       owned;       // Pins handed to the port
    logic       m_scl_oe;    // Master pulls SCL
    logic       m_sda_oe;    // Master pulls SDA
    int         failures;
    int         compares;
    logic [7:0] d;
    logic [7:0] b;
    logic       ack;
    logic       ten;
    logic       hit;
    logic       ss;

    ////////////////////////////////////////////////////////////////////////////////
    // Open-drain wires with pull-ups: low if anyone pulls
    assign line_lvl.scl = ~(line_oe.scl | m_scl_oe);
    assign line_lvl.sda = ~(line_oe.sda | m_sda_oe);

    isc_ctrl DUT (
        .sys_clk_in     (sys_clk_in),
        .rst_in         (rst_in),
        .addr_in        (addr_r),
        .wdata_in       (wdata_r),
        .wr_in          (wr_r),
        .rd_in          (rd_r),
        .rdata_out      (rdata),
        .irq_out        (irq),
        .line_in        (line_lvl),
        .line_out       (),
        .line_oe_out    (line_oe),
        .pins_owned_out (owned)
    );

    isc_mst_model MST (
        .scl_in     (line_lvl.scl),
        .sda_in     (line_lvl.sda),
        .scl_oe_out (m_scl_oe),
        .sda_oe_out (m_sda_oe)
    );

    // Free-running clock
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port tasks; each starts on a fresh edge so strobes never double up
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk_in);
        addr_r  <= a;
        wdata_r <= v;
        wr_r    <= 1'b1;
        @(posedge sys_clk_in);
        wr_r    <= 1'b0;
        #1;
    endtask : reg_wr

    // Read data stands only in the cycle after the strobe edge
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge sys_clk_in);
        addr_r <= a;
        rd_r   <= 1'b1;
        @(posedge sys_clk_in);
        rd_r   <= 1'b0;
        #1;
        v = rdata;
    endtask : reg_rd

    task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        reg_rd(a, v);
        `CHK(v, e)
    endtask : chk_rd

    // Let registered outputs land, then look just past the edge
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : settle

    // Address-only transfer, checking the acknowledge; ten-bit adds the low byte
    task automatic addr_txn(input logic [7:0] v, input logic e, input logic t);
        MST.start_c();
        MST.wbyte(v, ack);
        `CHK(ack, e)
        if (t) begin
            MST.wbyte(8'ha0, ack);
            `CHK(ack, e)
        end
        MST.stop_c();
        settle(4);
    endtask : addr_txn

    task automatic complete_run;
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: whole run is a few thousand cycles
    initial begin
        #(20000 * 40);
        failures++;
        complete_run();
    end

    // Main sequence
    initial begin
        failures = 0;
        compares = 0;
        rst_in   = 1'b1;
        addr_r   = 3'h0;
        wdata_r  = 8'h00;
        wr_r     = 1'b0;
        rd_r     = 1'b0;
        repeat (12) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        settle(3);
        // Reset values, unmapped index reads zero
        `CHK(irq, 1'b0)
        `CHK(rdata, 8'h00)
        `CHK(owned, 1'b0)
        chk_rd(`ISC_OFF_CTRL, `ISC_CTRL_RST);
        chk_rd(`ISC_OFF_ADDR, `ISC_ADDR_RST);
        chk_rd(3'h7, 8'h00);
        // Enable bit hands the pins over and back
        reg_wr(`ISC_OFF_CTRL, 8'h20);
        settle(1);
        `CHK(owned, 1'b1)
        reg_wr(`ISC_OFF_CTRL, 8'h00);
        settle(1);
        `CHK(owned, 1'b0)
        // Mask-load mode redirects the address location
        reg_wr(`ISC_OFF_CTRL, {4'h2, `ISC_MODE_MSKLD});
        chk_rd(`ISC_OFF_ADDR, `ISC_MASK_RST);
        reg_wr(`ISC_OFF_ADDR, 8'h5e);
        chk_rd(`ISC_OFF_ADDR, 8'h5e);
        reg_wr(`ISC_OFF_ADDR, `ISC_MASK_RST);
        reg_wr(`ISC_OFF_CTRL, {4'h2, `ISC_MODE_SL7});
        chk_rd(`ISC_OFF_ADDR, `ISC_ADDR_RST);
        reg_wr(`ISC_OFF_ADDR, 8'ha0);
        reg_wr(`ISC_OFF_ADDR_HI, 8'h01);
        reg_wr(`ISC_OFF_INT_MASK, 8'h06);
        // Every mode code: only slave modes answer, only 1110/1111 flag Start/Stop
        for (int m = 0; m < 16; m++) begin
            ten = (m == 7 || m == 15);
            hit = (m == 6 || m == 7 || m == 14 || m == 15);
            ss  = (m >= 14);
            reg_wr(`ISC_OFF_CTRL, {4'h3, m[3:0]});
            addr_txn(ten ? {`ISC_TEN_HDR, 2'b01, 1'b0} : 8'ha0, hit, ten);
            reg_rd(`ISC_OFF_INT_STAT, d);
            `CHK(d & 8'h06, ss ? 8'h06 : 8'h00)
            `CHK(irq, ss)
            if (ss) begin
                // Masking hides the pending bits from the interrupt line
                reg_wr(`ISC_OFF_INT_MASK, 8'h00);
                `CHK(irq, 1'b0)
                reg_wr(`ISC_OFF_INT_MASK, 8'h06);
            end
            reg_wr(`ISC_OFF_INT_STAT, 8'h07);
            `CHK(irq, 1'b0)
        end
        // Second data byte on an unread buffer overflows
        reg_rd(`ISC_OFF_BUF, d);
        reg_wr(`ISC_OFF_CTRL, 8'h36);
        MST.start_c();
        MST.wbyte(8'ha0, ack);
        `CHK(ack, 1'b1)
        MST.wbyte(8'h11, ack);
        `CHK(ack, 1'b1)
        MST.wbyte(8'h22, ack);
        `CHK(ack, 1'b0)
        MST.stop_c();
        settle(4);
        reg_rd(`ISC_OFF_CTRL, d);
        `CHK(d & 8'h40, 8'h40)
        chk_rd(`ISC_OFF_BUF, 8'h11);
        reg_wr(`ISC_OFF_CTRL, 8'h36);
        chk_rd(`ISC_OFF_CTRL, 8'h36);
        reg_wr(`ISC_OFF_INT_STAT, 8'h07);
        // Read request: acknowledge, stretch, release on hold bit
        MST.start_c();
        MST.wbyte(8'ha1, ack);
        `CHK(ack, 1'b1)
        settle(20);
        `CHK(line_oe.scl, 1'b1)
        chk_rd(`ISC_OFF_CTRL, 8'h26);
        chk_rd(`ISC_OFF_INT_STAT, 8'h01);
        reg_wr(`ISC_OFF_BUF, 8'h5a);
        settle(8);
        `CHK(line_oe.scl, 1'b1)
        reg_wr(`ISC_OFF_CTRL, 8'h36);
        settle(2);
        `CHK(line_oe.scl, 1'b0)
        // Buffer write in mid-byte collides and is dropped
        fork
            MST.rbyte(b, 1'b0);
            begin
                settle(40);
                reg_wr(`ISC_OFF_BUF, 8'hc3);
            end
        join
        MST.stop_c();
        settle(4);
        `CHK(b, 8'h5a)
        reg_rd(`ISC_OFF_CTRL, d);
        `CHK(d & 8'h80, 8'h80)
        complete_run();
    end
endmodule : i2c_slave_port_control_tb
